// ===== bra_core.sv
// Byte register ALU: read, compute and write sequencer with flag register.
// Contract
// RULE1: Operator 010 ORs both operands into the selected destination.
// RULE2: Operator 011 XORs both operands into the selected destination.
// RULE3: Operator 100 ANDs both operands into the selected destination.
// RULE4: Operator 101 shifts the source byte right by one bit.
// RULE5: Operator 110 adds both operands without the incoming carry.
// RULE6: Operator 111 adds both operands plus the current carry flag.
// RULE7: Read-modify-write reads the addressed register and writes it back.
// RULE8: Move-to reads the addressed register, writes the first-byte register.
// RULE9: Move-from writes first-byte register op immediate to the register.
// RULE10: Move-from shifts the first-byte register into the addressed one.
// RULE11: Op codes 111, 110, 101 are decoded; lower op codes are refused.
// RULE12: Operator 001 shifts the source byte left by one bit.
// RULE13: Shifts move the outgoing bit to carry and old carry in.
// RULE14: Select bit swaps the immediate for the first-byte register operand.
// RULE15: Adds keep eight bits and capture the carry out in the flag.
// RULE16: One read, compute, write pass; only destination and carry change.
`timescale 1ns/1ps
module bra_core #(
  parameter int DATA_W = bra_pkg::DATA_W,
  parameter int ADDR_W = bra_pkg::ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire bra_pkg::bra_instr_t instr,
  output logic instr_ready,
  output logic done,
  output logic illegal_opcode,
  output logic reg_rd_en,
  output logic [ADDR_W-1:0] reg_rd_addr,
  input wire logic [DATA_W-1:0] reg_rd_data,
  output bra_pkg::bra_reg_wr_t reg_wr,
  output logic [DATA_W-1:0] first_byte_received_reg,
  output logic alu_carry
);
  typedef enum logic [1:0] {
    BRA_IDLE,
    BRA_READ,
    BRA_EXEC,
    BRA_WRITE
  } bra_state_t;

  function automatic logic legal_opcode(input logic [2:0] opc);
    legal_opcode = (opc == bra_pkg::OPC_RMW) ||
                   (opc == bra_pkg::OPC_MOVE_TO) ||
                   (opc == bra_pkg::OPC_MOVE_FROM);
  endfunction

  // Reset release is retimed so every flop leaves reset on the same edge.
  logic [1:0] rst_sync_ff, nxt_rst_sync;
  logic rst_int_n;

  always_comb begin
    nxt_rst_sync = {rst_sync_ff[0], 1'b1};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= nxt_rst_sync;
    end
  end
  assign rst_int_n = rst_sync_ff[1];

  bra_state_t state_ff, nxt_state;
  bra_pkg::bra_instr_t instr_ff, nxt_instr;
  bra_pkg::bra_reg_wr_t wr_ff, nxt_wr;
  logic [DATA_W-1:0] fbr_ff, nxt_fbr;
  logic carry_ff, nxt_carry;
  logic done_ff, nxt_done;
  logic illegal_ff, nxt_illegal;

  logic take_instr;
  logic take_legal;
  logic exec_step;
  logic dest_is_fbr;

  logic [DATA_W-1:0] opnd_a;
  logic [DATA_W-1:0] opnd_b;
  logic [DATA_W-1:0] alu_result;
  logic alu_cout;
  logic alu_cwe;

  // An offered instruction is only looked at while the sequencer is idle.
  assign take_instr = instr_valid && (state_ff == BRA_IDLE);
  assign take_legal = take_instr && legal_opcode(instr.opcode); // [RULE11]
  assign exec_step = (state_ff == BRA_EXEC);
  assign dest_is_fbr = (instr_ff.opcode == bra_pkg::OPC_MOVE_TO); // [RULE8]

  always_comb begin
    opnd_a = reg_rd_data; // [RULE7] [RULE8]
    if (instr_ff.opcode == bra_pkg::OPC_MOVE_FROM) begin
      opnd_a = fbr_ff; // [RULE9] [RULE10]
    end
    opnd_b = instr_ff.immediate_byte;
    if (instr_ff.use_fbr) begin
      opnd_b = fbr_ff; // [RULE14]
    end
  end

  bra_alu #(
    .DATA_W(DATA_W)
  ) u_alu (
    .operator_sel(instr_ff.operator_sel),
    .opnd_a(opnd_a),
    .opnd_b(opnd_b),
    .carry_in(carry_ff),
    .result(alu_result),
    .carry_out(alu_cout),
    .carry_we(alu_cwe)
  );

  // Sequencer: one read, one compute and, except for move-to, one write step per legal instruction.
  always_comb begin
    nxt_state = state_ff;
    nxt_done = 1'b0;
    nxt_illegal = 1'b0;
    case (state_ff)
      BRA_IDLE: begin
        if (take_legal) begin
          nxt_state = BRA_READ;
        end else if (take_instr) begin
          nxt_illegal = 1'b1; // [RULE11] [RULE16]
          nxt_done = 1'b1;
        end
      end
      BRA_READ: begin
        nxt_state = BRA_EXEC;
      end
      BRA_EXEC: begin
        if (dest_is_fbr) begin
          nxt_done = 1'b1;
          nxt_state = BRA_IDLE;
        end else begin
          nxt_state = BRA_WRITE;
        end
      end
      BRA_WRITE: begin
        nxt_done = 1'b1; // [RULE16]
        nxt_state = BRA_IDLE;
      end
      default: begin
        nxt_state = BRA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_ff <= BRA_IDLE;
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      done_ff <= nxt_done;
      illegal_ff <= nxt_illegal;
    end
  end

  // A refused opcode leaves the last accepted instruction in place.
  always_comb begin
    nxt_instr = instr_ff;
    if (take_legal) begin
      nxt_instr = instr;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      instr_ff <= '0;
    end else begin
      instr_ff <= nxt_instr;
    end
  end

  // The write strobe lasts one cycle; address and data hold until the next.
  always_comb begin
    nxt_wr = wr_ff;
    nxt_wr.en = 1'b0;
    if (exec_step && !dest_is_fbr) begin
      nxt_wr.en = 1'b1; // [RULE7] [RULE9] [RULE10]
      nxt_wr.addr = instr_ff.reg_addr;
      nxt_wr.data = alu_result;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      wr_ff <= '0;
    end else begin
      wr_ff <= nxt_wr;
    end
  end

  // The first-byte register and the carry change only in the compute step.
  always_comb begin
    nxt_fbr = fbr_ff;
    nxt_carry = carry_ff;
    if (exec_step && alu_cwe) begin
      nxt_carry = alu_cout; // [RULE13] [RULE15]
    end
    if (exec_step && dest_is_fbr) begin
      nxt_fbr = alu_result; // [RULE8]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      fbr_ff <= bra_pkg::FBR_RESET;
      carry_ff <= bra_pkg::CARRY_RESET;
    end else begin
      fbr_ff <= nxt_fbr;
      carry_ff <= nxt_carry;
    end
  end

  // The register file answers one cycle after the read strobe.
  assign instr_ready = (state_ff == BRA_IDLE);
  assign reg_rd_en = (state_ff == BRA_READ) &&
                     (instr_ff.opcode != bra_pkg::OPC_MOVE_FROM);
  assign reg_rd_addr = instr_ff.reg_addr;
  assign reg_wr = wr_ff;
  assign done = done_ff;
  assign illegal_opcode = illegal_ff;
  assign first_byte_received_reg = fbr_ff;
  assign alu_carry = carry_ff;
endmodule

// ===== bra_pkg.sv
// Shared constants and carrier types for the byte register ALU.
package bra_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int OPC_W = 3;
  localparam int OPR_W = 3;

  localparam logic [OPC_W-1:0] OPC_RMW = 3'h7;
  localparam logic [OPC_W-1:0] OPC_MOVE_TO = 3'h6;
  localparam logic [OPC_W-1:0] OPC_MOVE_FROM = 3'h5;

  localparam logic [OPR_W-1:0] OPR_MOVE = 3'h0;
  localparam logic [OPR_W-1:0] OPR_SHIFT_LEFT = 3'h1;
  localparam logic [OPR_W-1:0] OPR_OR = 3'h2;
  localparam logic [OPR_W-1:0] OPR_XOR = 3'h3;
  localparam logic [OPR_W-1:0] OPR_AND = 3'h4;
  localparam logic [OPR_W-1:0] OPR_SHIFT_RIGHT = 3'h5;
  localparam logic [OPR_W-1:0] OPR_ADD = 3'h6;
  localparam logic [OPR_W-1:0] OPR_ADD_CARRY = 3'h7;

  localparam logic [DATA_W-1:0] FBR_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;

  typedef struct packed {
    logic [OPC_W-1:0] opcode;
    logic [OPR_W-1:0] operator_sel;
    logic use_fbr;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] immediate_byte;
  } bra_instr_t;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bra_reg_wr_t;
endpackage

// ===== bra_alu.sv
// Combinational byte operator stage: logic, shifts through carry and adds.
`timescale 1ns/1ps
module bra_alu #(
  parameter int DATA_W = 8
) (
  input wire logic [2:0] operator_sel,
  input wire logic [DATA_W-1:0] opnd_a,
  input wire logic [DATA_W-1:0] opnd_b,
  input wire logic carry_in,
  output logic [DATA_W-1:0] result,
  output logic carry_out,
  output logic carry_we
);
  logic [DATA_W:0] sum;

  always_comb begin
    sum = '0;
    result = opnd_b;
    carry_out = carry_in;
    carry_we = 1'b0;
    case (operator_sel)
      bra_pkg::OPR_MOVE: begin
        result = opnd_b;
      end
      bra_pkg::OPR_SHIFT_LEFT: begin
        result = {opnd_a[DATA_W-2:0], carry_in}; // [RULE12] [RULE13]
        carry_out = opnd_a[DATA_W-1]; // [RULE13]
        carry_we = 1'b1;
      end
      bra_pkg::OPR_OR: begin
        result = opnd_a | opnd_b; // [RULE1]
      end
      bra_pkg::OPR_XOR: begin
        result = opnd_a ^ opnd_b; // [RULE2]
      end
      bra_pkg::OPR_AND: begin
        result = opnd_a & opnd_b; // [RULE3]
      end
      bra_pkg::OPR_SHIFT_RIGHT: begin
        result = {carry_in, opnd_a[DATA_W-1:1]}; // [RULE4] [RULE13]
        carry_out = opnd_a[0]; // [RULE13]
        carry_we = 1'b1;
      end
      bra_pkg::OPR_ADD: begin
        sum = {1'b0, opnd_a} + {1'b0, opnd_b}; // [RULE5]
        result = sum[DATA_W-1:0]; // [RULE15]
        carry_out = sum[DATA_W]; // [RULE15]
        carry_we = 1'b1;
      end
      bra_pkg::OPR_ADD_CARRY: begin
        sum = {1'b0, opnd_a} + {1'b0, opnd_b} +
              {{DATA_W{1'b0}}, carry_in}; // [RULE6]
        result = sum[DATA_W-1:0]; // [RULE15]
        carry_out = sum[DATA_W]; // [RULE15]
        carry_we = 1'b1;
      end
      default: begin
        result = opnd_b;
      end
    endcase
  end
endmodule

// ===== bra_core_asserts.sv
// Port timing checks for the byte register ALU.
`timescale 1ns/1ps
module bra_core_asserts (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire bra_pkg::bra_instr_t instr,
  input wire logic instr_ready,
  input wire logic done,
  input wire logic illegal_opcode,
  input wire logic reg_rd_en,
  input wire bra_pkg::bra_reg_wr_t reg_wr,
  input wire logic [bra_pkg::DATA_W-1:0] first_byte_received_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence take_s;
    instr_valid && instr_ready;
  endsequence
  sequence wr_done_s;
    reg_wr.en ##1 done;
  endsequence
  illegal_pulse_a: assert property (
    take_s and instr.opcode < bra_pkg::OPC_MOVE_FROM |=>
    illegal_opcode && done) else $error("refused opcode not flagged");
  legal_clean_a: assert property (
    take_s and instr.opcode >= bra_pkg::OPC_MOVE_FROM |=>
    !illegal_opcode && !instr_ready) else $error("legal opcode flagged");
  rmw_steps_a: assert property (
    take_s and instr.opcode == bra_pkg::OPC_RMW |=>
    reg_rd_en ##2 wr_done_s) else $error("rmw sequence wrong");
  rmw_addr_a: assert property (
    take_s and instr.opcode == bra_pkg::OPC_RMW |->
    ##3 reg_wr.addr == $past(instr.reg_addr, 3)) else $error("rmw addr");
  move_to_a: assert property (
    take_s and instr.opcode == bra_pkg::OPC_MOVE_TO |=>
    reg_rd_en ##1 !reg_wr.en ##1 done && !reg_wr.en)
    else $error("move-to sequence wrong");
  move_from_a: assert property (
    take_s and instr.opcode == bra_pkg::OPC_MOVE_FROM |=>
    !reg_rd_en ##2 wr_done_s) else $error("move-from sequence wrong");
  fbr_hold_a: assert property (
    take_s and instr.opcode != bra_pkg::OPC_MOVE_TO |=>
    $stable(first_byte_received_reg) [*4]) else $error("first byte changed");
  illegal_done_a: assert property (illegal_opcode |-> done)
    else $error("illegal pulse without done");
  wr_pulse_a: assert property (reg_wr.en |=> !reg_wr.en)
    else $error("write strobe too long");
endmodule

bind bra_core bra_core_asserts u_chk (.clk_sys, .rst_n, .instr_valid, .instr,
  .instr_ready, .done, .illegal_opcode, .reg_rd_en, .reg_wr,
  .first_byte_received_reg);

// ===== bra_regfile_model.sv
// Chip register file model answering the ALU's reads and taking its writes.
`timescale 1ns/1ps
module bra_regfile_model (
  input wire logic clk_sys,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_rd_addr,
  output logic [7:0] reg_rd_data,
  input wire bra_pkg::bra_reg_wr_t reg_wr
);
  logic [7:0] mem [128];
  initial reg_rd_data = 8'h00;
  always @(posedge clk_sys) begin
    // Outside a read the bus toggles so a stale byte is never reused.
    reg_rd_data <= reg_rd_en ? mem[reg_rd_addr] : ~reg_rd_data;
    if (reg_wr.en) mem[reg_wr.addr] <= reg_wr.data;
  end
endmodule

// ===== byte_register_alu_ops_tb_top.sv
// Self-checking bench running every legal opcode and operator pair, then each refused opcode with operator 110.
`timescale 1ns/1ps
module byte_register_alu_ops_tb_top;
  logic clk_sys, rst_n, instr_valid, instr_ready, done, ill, alu_carry;
  logic illegal_opcode, reg_rd_en, cy, us;
  logic [6:0] reg_rd_addr, a;
  logic [7:0] reg_rd_data, fbr, fbr_exp, rv, src;
  logic [8:0] r;
  logic [2:0] opc, opr;
  bra_pkg::bra_instr_t instr;
  bra_pkg::bra_reg_wr_t reg_wr;
  int bad_count = 0;
  int n_tests = 0;
  bra_core u_dut (.clk_sys, .rst_n, .instr_valid, .instr, .instr_ready, .done,
    .illegal_opcode, .reg_rd_en, .reg_rd_addr, .reg_rd_data, .reg_wr,
    .first_byte_received_reg(fbr), .alu_carry);
  bra_regfile_model u_rf (.clk_sys, .reg_rd_en, .reg_rd_addr, .reg_rd_data,
    .reg_wr);
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic exec(input logic [2:0] oc, op, input logic u,
      input logic [6:0] ad);
    int n;
    instr_valid <= 1'b1;
    instr <= '{oc, op, u, ad, 8'hc5};
    n = 0;
    @(negedge clk_sys);
    while (instr_ready !== 1'b1 && n++ < 50) @(negedge clk_sys);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    @(negedge clk_sys);
    while (done !== 1'b1 && n++ < 50) @(negedge clk_sys);
    check("done", 8'(done), 8'h01);
    ill = illegal_opcode;
    @(posedge clk_sys);
  endtask
  function automatic logic [8:0] ref_op(logic [2:0] o, logic [7:0] x, y,
      logic c);
    case (o)
      3'h0: return {c, y};
      3'h1: return {x, c};
      3'h2: return {c, x | y};
      3'h3: return {c, x ^ y};
      3'h4: return {c, x & y};
      3'h5: return {x[0], c, x[7:1]};
      3'h6: return {1'b0, x} + y;
      default: return {1'b0, x} + y + c;
    endcase
  endfunction
  initial begin
    #(25 * 2000);
    bad_count++;
    close_out();
  end
  initial begin
    rst_n = 0;
    instr_valid = 0;
    instr = '0;
    fbr_exp = bra_pkg::FBR_RESET;
    cy = 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int k = 0; k < 24; k++) begin
      opc = 3'h7 - 3'(k / 8);
      opr = 3'(k);
      us = opr[0] ^ opc[1];
      a = 7'(k + 3);
      rv = 8'h9a + 8'(k * 37);
      u_rf.mem[a] = rv;
      src = (opc == 3'h5) ? fbr_exp : rv;
      r = ref_op(opr, src, us ? fbr_exp : 8'hc5, cy);
      exec(opc, opr, us, a);
      if (opc == 3'h6) begin
        check("fbr", fbr, r[7:0]);
        check("kept", u_rf.mem[a], rv);
        fbr_exp = r[7:0];
      end else begin
        check("dest", u_rf.mem[a], r[7:0]);
      end
      check("carry", 8'(alu_carry), 8'(r[8]));
      cy = r[8];
    end
    for (int k = 0; k < 5; k++) begin
      exec(3'(k), 3'h6, 1'b0, 7'h01);
      check("refused", 8'(ill), 8'h01);
      check("fbr", fbr, fbr_exp);
      check("carry", 8'(alu_carry), 8'(cy));
    end
    close_out();
  end
endmodule
